// ==== hdl/irp_pkg.sv ====
// Constants and carrier types of the interrogation receiver port
package irp_pkg;
  localparam logic [5:0] DEV_CODE = 6'o52;
  localparam int MASK_BIT_BE = 3;
  localparam int CLK_MHZ = 50;
  localparam int TICKS_PER_US = 16;
  localparam logic [6:0] ACC_STEP = 7'(TICKS_PER_US);
  localparam logic [6:0] ACC_MOD = 7'(CLK_MHZ);
  localparam logic [15:0] US_MAX = 16'hFFFF;
  localparam logic [1:0] REC_WORDS = 2'h3;
  localparam int BUF_WORDS_DEF = 1024;
  // Big-endian field positions in record word 2
  localparam int POS_SIDE_BE = 0;
  localparam int POS_TYPE_BE = 4;
  localparam int POS_LOCK_BE = 6;
  localparam logic [3:0] TYPE_ALLCALL_LO = 4'h1;
  localparam logic [3:0] TYPE_ALLCALL_HI = 4'h3;

  typedef enum logic [0:0] {
    IRP_IDLE = 1'b0,
    IRP_WRITE = 1'b1
  } irp_fsm_type;

  typedef struct packed {
    logic strobe;
    logic antenna_side_flag;
    logic [3:0] interrogation_type_code;
    logic [13:0] azimuth;
    logic [1:0] lockout_code;
  } irp_rx_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } irp_mem_type;

  function automatic int be2le(input int be_pos);
    return 15 - be_pos;
  endfunction : be2le
endpackage : irp_pkg

// ==== hdl/irp_port.sv ====
// Interrogation receiver port: bus strobes, counters, record writer
`timescale 1ns/1ps
`default_nettype none
module irp_port #(
  parameter logic [15:0] BUF_WORDS = 16'(irp_pkg::BUF_WORDS_DEF)
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  input wire logic [5:0] I_DEV_SEL,
  input wire logic I_START,
  input wire logic I_CLEAR,
  input wire logic I_PULSE,
  input wire logic I_BUS_WIDE_IO_RESET,
  input wire logic I_MASK_OUT,
  input wire logic I_INPUT_A,
  input wire logic I_INPUT_C,
  input wire logic I_OUTPUT_A,
  input wire logic I_OUTPUT_C,
  input wire logic [15:0] I_DATA,
  input wire logic I_MEM_READY,
  input wire irp_pkg::irp_rx_type I_RX,
  output logic [15:0] O_DATA,
  output logic O_DATA_VALID,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_INT,
  output var irp_pkg::irp_mem_type O_MEM
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic busy;
    logic done;
    logic done2;
    logic mask;
    logic int_req;
    logic [15:0] count;
    logic [15:0] start_ptr;
    logic [15:0] mar;
    logic [15:0] rd_data;
    logic rd_valid;
    irp_pkg::irp_rx_type rx1;
    irp_pkg::irp_rx_type rx2;
    logic strobe_d;
    logic [6:0] acc;
    logic [3:0] sub;
    logic [15:0] us_since;
    logic [15:0] fine_since;
    irp_pkg::irp_fsm_type fsm;
    logic [1:0] idx;
    logic [15:0] rec0;
    logic [15:0] rec1;
    logic [15:0] rec2;
    irp_pkg::irp_mem_type mem;
  } irp_state_type;

  irp_state_type st;
  irp_state_type next_st;

  if (BUF_WORDS < 16'(irp_pkg::REC_WORDS)) begin : g_chk
    $error("BUF_WORDS must hold at least one record");
  end

  logic sel;
  logic s_start;
  logic s_clear;
  logic s_pulse;
  logic rx_event;
  logic is_allcall;
  logic room;
  logic [15:0] used;

  assign sel = (I_DEV_SEL == irp_pkg::DEV_CODE);
  assign s_start = I_START & sel;
  assign s_clear = I_CLEAR & sel;
  assign s_pulse = I_PULSE & sel;
  // Edge on second sync stage; first stage feeds only the second
  assign rx_event = st.rx2.strobe & ~st.strobe_d;
  assign is_allcall = (st.rx2.interrogation_type_code >=
                       irp_pkg::TYPE_ALLCALL_LO) &&
                      (st.rx2.interrogation_type_code <=
                       irp_pkg::TYPE_ALLCALL_HI);
  assign used = st.mar - st.start_ptr;
  // Judged before the first word, so no record ever lands in part
  assign room = (used <= BUF_WORDS - 16'(irp_pkg::REC_WORDS));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.rx1 = I_RX;
    next_st.rx2 = st.rx1;
    next_st.strobe_d = st.rx2.strobe;
    next_st.rd_valid = 1'b0;

    // Exact 16 fine ticks per 50 clocks by fractional accumulation
    next_st.acc = st.acc + irp_pkg::ACC_STEP;
    if (next_st.acc >= irp_pkg::ACC_MOD) begin
      next_st.acc = next_st.acc - irp_pkg::ACC_MOD;
      next_st.fine_since = st.fine_since + 16'h0001;
      next_st.sub = st.sub + 4'h1;
      if (st.sub == 4'hF && st.us_since != irp_pkg::US_MAX) begin
        next_st.us_since = st.us_since + 16'h0001;
      end
    end

    if (s_pulse) begin
      next_st.done2 = 1'b0;
    end
    if (s_start) begin
      next_st.busy = 1'b1;
      next_st.done = 1'b0;
      next_st.done2 = 1'b0;
    end
    if (s_clear || I_BUS_WIDE_IO_RESET) begin
      next_st.busy = 1'b0;
      next_st.done = 1'b0;
      next_st.done2 = 1'b0;
    end
    // Mask-out is not device-qualified: every device takes its own bit
    if (I_BUS_WIDE_IO_RESET) begin
      next_st.mask = 1'b0;
    end else if (I_MASK_OUT) begin
      next_st.mask = I_DATA[irp_pkg::be2le(irp_pkg::MASK_BIT_BE)];
    end

    // Idle output-C is harmless: the counter is forced to zero below
    if (I_OUTPUT_C && sel) begin
      next_st.count = next_st.count - 16'h0001;
    end
    if (I_INPUT_A && sel) begin
      next_st.rd_data = st.mar;
      next_st.rd_valid = 1'b1;
    end
    if (I_INPUT_C && sel) begin
      next_st.rd_data = st.count;
      next_st.rd_valid = 1'b1;
    end

    // Every interrogation while busy counts, even one the writer has to drop
    if (rx_event && st.busy) begin
      next_st.count = next_st.count + 16'h0001;
    end

    // Record writer; a write in flight drains before new capture
    case (st.fsm)
      irp_pkg::IRP_IDLE: begin
        if (rx_event && st.busy) begin
          if (room) begin
            next_st.done2 = 1'b1;
            next_st.rec0 = is_allcall ? st.us_since
                                      : st.fine_since;
            next_st.rec1 = {2'b00, st.rx2.azimuth};
            next_st.rec2 = 16'h0000;
            next_st.rec2[irp_pkg::be2le(irp_pkg::POS_SIDE_BE)] =
              st.rx2.antenna_side_flag;
            next_st.rec2[irp_pkg::be2le(irp_pkg::POS_TYPE_BE) +: 4] =
              st.rx2.interrogation_type_code;
            if (!is_allcall) begin
              next_st.rec2[irp_pkg::be2le(irp_pkg::POS_LOCK_BE) +: 2] =
                st.rx2.lockout_code;
            end
            next_st.idx = 2'h0;
            next_st.fsm = irp_pkg::IRP_WRITE;
            next_st.mem.we = 1'b1;
            next_st.mem.addr = st.mar;
            next_st.mem.wdata = next_st.rec0;
          end else begin
            next_st.done = 1'b1;
          end
        end
      end
      irp_pkg::IRP_WRITE: begin
        if (I_MEM_READY) begin
          next_st.mar = st.mar + 16'h0001;
          next_st.idx = st.idx + 2'h1;
          next_st.mem.addr = st.mar + 16'h0001;
          next_st.mem.wdata = (st.idx == 2'h0) ? st.rec1 : st.rec2;
          if (st.idx == irp_pkg::REC_WORDS - 2'h1) begin
            next_st.mem.we = 1'b0;
            next_st.fsm = irp_pkg::IRP_IDLE;
          end
        end
      end
      default: begin
        next_st.fsm = irp_pkg::IRP_IDLE;
        next_st.mem.we = 1'b0;
      end
    endcase

    // All-call restarts both elapsed-time counters
    if (rx_event && is_allcall) begin
      next_st.us_since = 16'h0000;
      next_st.fine_since = 16'h0000;
      next_st.sub = 4'h0;
    end

    // Bus reset leaves start pointer and address alone
    if (I_OUTPUT_A && sel) begin
      next_st.start_ptr = I_DATA;
      next_st.mar = I_DATA;
    end
    if (!next_st.busy) begin
      next_st.count = 16'h0000;
    end
    next_st.int_req = (next_st.done | next_st.done2) & ~next_st.mask;
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st <= '0;
    end else if (I_CE) begin
      st <= next_st;
    end
  end

  assign O_DATA = st.rd_data;
  assign O_DATA_VALID = st.rd_valid;
  assign O_BUSY = st.busy;
  assign O_DONE = st.done;
  assign O_INT = st.int_req;
  assign O_MEM = st.mem;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N || !I_CE);

  a_start_sets_busy: assert property (
    s_start && !s_clear && !I_BUS_WIDE_IO_RESET
    |=> O_BUSY && !O_DONE && !st.done2)
    else $error("start did not set busy");
  a_clear_stops: assert property (
    s_clear |=> !O_BUSY && !O_DONE && st.count == 16'h0000)
    else $error("clear did not stop device");
  a_pulse_withdraws: assert property (
    s_pulse && !rx_event ##1 I_CE |-> !st.done2)
    else $error("pulse left secondary completion");
  a_reset_mask_clr: assert property (
    I_BUS_WIDE_IO_RESET |=> !st.mask && !O_BUSY && st.count == 16'h0000)
    else $error("bus reset incomplete");
  a_reset_keeps_ptr: assert property (
    I_BUS_WIDE_IO_RESET && !(I_OUTPUT_A && sel) && !O_MEM.we
    |=> st.start_ptr == $past(st.start_ptr) && st.mar == $past(st.mar))
    else $error("bus reset moved the buffer pointers");
  a_idle_count_zero: assert property (
    !O_BUSY |-> st.count == 16'h0000)
    else $error("counter nonzero while idle");
  a_rx_sets_done2: assert property (
    rx_event && st.busy && room && st.fsm == irp_pkg::IRP_IDLE &&
    !s_clear && !I_BUS_WIDE_IO_RESET && !s_start |=> st.done2 && O_MEM.we)
    else $error("interrogation not flagged");
  a_record_addr: assert property (
    rx_event && st.busy && room && st.fsm == irp_pkg::IRP_IDLE
    |=> O_MEM.we && O_MEM.addr == $past(st.mar))
    else $error("record not started at address register");
  a_allcall_time: assert property (
    rx_event && st.busy && room && st.fsm == irp_pkg::IRP_IDLE &&
    is_allcall |=> O_MEM.wdata == $past(st.us_since))
    else $error("all-call time word wrong");
  a_overflow_keeps: assert property (
    rx_event && st.busy && !room && st.fsm == irp_pkg::IRP_IDLE &&
    !(I_OUTPUT_A && sel) |=> O_DONE && !O_MEM.we && st.mar == $past(st.mar))
    else $error("overflow wrote or lost the address");
  a_skip_primary: assert property (
    $rose(O_DONE) |-> $past(rx_event && st.busy && !room))
    else $error("skip flag rose without overflow");
  a_read_addr: assert property (
    I_INPUT_A && sel && !I_INPUT_C |=> O_DATA_VALID && O_DATA == $past(st.mar))
    else $error("input-A data wrong");
  a_read_count: assert property (
    I_INPUT_C && sel |=> O_DATA_VALID && O_DATA == $past(st.count))
    else $error("input-C data wrong");
  a_load_pointer: assert property (
    I_OUTPUT_A && sel |=> st.mar == $past(I_DATA) &&
                          st.start_ptr == $past(I_DATA))
    else $error("output-A load failed");
  a_dec_count: assert property (
    I_OUTPUT_C && sel && st.busy && !rx_event && !s_clear &&
    !I_BUS_WIDE_IO_RESET
    |=> st.count == $past(st.count) - 16'h0001)
    else $error("output-C did not decrement");
  a_word_advance: assert property (
    O_MEM.we && I_MEM_READY && !(I_OUTPUT_A && sel)
    |=> st.mar == $past(st.mar) + 16'h0001)
    else $error("address did not advance");
  a_int_masked: assert property (
    st.mask |-> !O_INT)
    else $error("interrupt passed mask");

  c_record_done: cover property (O_MEM.we ##[1:20] !O_MEM.we);
  c_overflow: cover property ($rose(O_DONE));
  c_pulse_clear: cover property (st.done2 ##1 s_pulse ##1 !st.done2);
  c_count_read: cover property (I_INPUT_C && sel && st.count != 16'h0000);
  c_allcall_rec: cover property (rx_event && st.busy && is_allcall);

endmodule : irp_port
`default_nettype wire

// ==== tb/irp_mem_model.sv ====
// Host memory channel model that accepts record words
`timescale 1ns/1ps
`default_nettype none
module irp_mem_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_slow,
  input wire irp_pkg::irp_mem_type i_mem,
  output logic o_ready
);
  logic [15:0] store [0:1023];
  logic tgl;
  // Slow mode accepts every other cycle, so the writer must hold its word
  assign o_ready = !i_slow || tgl;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tgl <= 1'b0;
    end else begin
      tgl <= !tgl;
      if (i_mem.we && o_ready) begin
        store[i_mem.addr[9:0]] <= i_mem.wdata;
      end
    end
  end
endmodule : irp_mem_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench of the interrogation receiver port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic I_CLK = 1'b0;
  logic I_ARST_N = 1'b0;
  logic [8:0] st = '0;
  logic [5:0] dev = 6'o52;
  logic [15:0] dat = 16'h0000;
  logic slow = 1'b0;
  logic ce = 1'b1;
  irp_pkg::irp_rx_type rx = '0;
  logic [15:0] rdata;
  logic rvalid, busy, done, irq, ready;
  irp_pkg::irp_mem_type mem;
  int fail_count = 0;
  int n_checks = 0;
  time t_ac, t_rise;
  always #10 I_CLK = ~I_CLK;
  irp_port #(.BUF_WORDS(16'h0006)) u_irp_port (.I_CLK(I_CLK),
    .I_ARST_N(I_ARST_N), .I_CE(ce), .I_DEV_SEL(dev), .I_START(st[0]),
    .I_CLEAR(st[1]), .I_PULSE(st[2]), .I_BUS_WIDE_IO_RESET(st[3]),
    .I_MASK_OUT(st[4]), .I_INPUT_A(st[5]), .I_INPUT_C(st[6]),
    .I_OUTPUT_A(st[7]), .I_OUTPUT_C(st[8]), .I_DATA(dat),
    .I_MEM_READY(ready), .I_RX(rx), .O_DATA(rdata),
    .O_DATA_VALID(rvalid), .O_BUSY(busy), .O_DONE(done), .O_INT(irq),
    .O_MEM(mem));
  irp_mem_model u_irp_mem_model (.i_clk(I_CLK), .i_arst_n(I_ARST_N),
    .i_slow(slow), .i_mem(mem), .o_ready(ready));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic near(input logic [15:0] got, input int e, input int tol);
    chk(16'(got >= e - tol && got <= e + tol), 16'h0001);
  endtask : near
  function automatic logic [15:0] mw(input logic [15:0] a);
    return u_irp_mem_model.store[a[9:0]];
  endfunction : mw
  // Strobe index: start clear pulse busrst mask ina inc outa outc
  task automatic op(input int k, input logic [15:0] d,
    input logic [5:0] dv = 6'o52);
    @(negedge I_CLK);
    st[k] = 1'b1;
    dat = d;
    dev = dv;
    @(negedge I_CLK);
    st = '0;
  endtask : op
  task automatic rd(input int k, input logic [15:0] exp);
    op(k, 16'h0000);
    if (!rvalid) @(negedge I_CLK);
    chk(16'(rvalid), 16'h0001);
    chk(rdata, exp);
  endtask : rd
  task automatic flags(input logic b, input logic d, input logic i);
    @(negedge I_CLK);
    chk({13'h0, busy, done, irq}, {13'h0, b, d, i});
  endtask : flags
  task automatic rec(input logic f, input logic [3:0] ty,
    input logic [13:0] az, input logic [1:0] lk);
    bit seen;
    @(negedge I_CLK);
    rx.antenna_side_flag = f;
    rx.interrogation_type_code = ty;
    rx.azimuth = az;
    rx.lockout_code = lk;
    repeat (4) @(negedge I_CLK);
    rx.strobe = 1'b1;
    t_rise = $time;
    seen = 1'b0;
    // Fields stay put until the next record, well past the hold time
    for (int i = 0; i < 40; i++) begin
      @(negedge I_CLK);
      if (i == 4) rx.strobe = 1'b0;
      if (mem.we) seen = 1'b1;
      else if (seen && i > 4) break;
    end
  endtask : rec
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    op(8, 16'hFFFF);
    rd(6, 16'h0000);
    op(7, 16'h0100);
    rd(5, 16'h0100);
    op(0, 16'h0000, 6'o51);
    flags(0, 0, 0);
    ce = 1'b0;
    op(0, 16'h0000);
    flags(0, 0, 0);
    ce = 1'b1;
    op(0, 16'h0000);
    flags(1, 0, 0);
  endtask : t_regs
  task automatic t_rec;
    rec(1'b1, 4'h1, 14'h2AAA, 2'b11);
    t_ac = t_rise;
    chk(mw(16'h0101), 16'h2AAA);
    chk(mw(16'h0102), 16'h8800);
    flags(1, 0, 1);
    op(2, 16'h0000);
    flags(1, 0, 0);
    rd(5, 16'h0103);
    repeat (200) @(negedge I_CLK);
    rec(1'b0, 4'h2, 14'h1555, 2'b00);
    near(mw(16'h0103), int'((t_rise - t_ac) / 1000), 1);
    t_ac = t_rise;
    op(7, 16'h0110);
    repeat (100) @(negedge I_CLK);
    rec(1'b0, 4'h4, 14'h0000, 2'b10);
    chk(mw(16'h0112), 16'h2400);
    near(mw(16'h0110), int'((t_rise - t_ac) * 16 / 1000), 2);
    rd(6, 16'h0003);
    op(8, 16'h1234);
    rd(6, 16'h0002);
  endtask : t_rec
  task automatic t_types;
    for (int ty = 0; ty < 9; ty++) begin
      op(7, 16'h0300);
      rec(1'b0, 4'(ty), 14'h0000, 2'b00);
      chk(mw(16'h0302), {1'b0, 4'(ty), 11'h000});
    end
    op(1, 16'h0000);
    flags(0, 0, 0);
    rd(6, 16'h0000);
  endtask : t_types
  task automatic t_ovf;
    slow = 1'b1;
    op(7, 16'h0200);
    op(0, 16'h0000);
    repeat (3) rec(1'b0, 4'h4, 14'h0123, 2'b01);
    flags(1, 1, 1);
    rd(5, 16'h0206);
    rd(6, 16'h0003);
    op(4, 16'h1000);
    flags(1, 1, 0);
    op(3, 16'h0000);
    flags(0, 0, 0);
    rd(5, 16'h0206);
    op(0, 16'h0000);
    rec(1'b0, 4'h4, 14'h0123, 2'b01);
    flags(1, 1, 1);
  endtask : t_ovf
  // ****************************************
  // Run control
  // ****************************************
  task automatic test_done;
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge I_CLK);
    @(negedge I_CLK);
    I_ARST_N = 1'b1;
    t_regs;
    t_rec;
    t_types;
    t_ovf;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge I_CLK);
    fail_count++;
    test_done;
  end
endmodule : tb
`default_nettype wire
